// File: clk_cfg.svh
// Purpose: Offsets, field positions, reset values and counts for the clock control block
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one aligned word per register
// Notes:   Definitions only
`ifndef CLK_CFG_SVH
`define CLK_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define CFG_ADDR_W 4
`define CFG_OFS_MULT 4'h0
`define CFG_OFS_STATUS 4'h4
`define CFG_OFS_XCFG 4'h8

// ----------------------------------------------------------------------------
// Multiplier register
// ----------------------------------------------------------------------------
`define CFG_RATIO_BYPASS 4'h0
`define CFG_RATIO_MAX 4'hA

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define CFG_ST_LOCKED 0
`define CFG_ST_MCLK_FLAG 3
`define CFG_ST_MCLK_CLR 4
`define CFG_ST_MCLK_OFF 6
`define CFG_ST_CPU_CLOCK_DIVIDE_SELECT_LO 7
`define CFG_ST_CPU_CLOCK_DIVIDE_SELECT_HI 8
`define CFG_CPU_CLOCK_DIVIDE_SELECT_BY2 2'h2
`define CFG_CPU_CLOCK_DIVIDE_SELECT_BY1 2'h3

// ----------------------------------------------------------------------------
// External interface config 2 fields
// ----------------------------------------------------------------------------
`define CFG_XC_EXT_CLOCK_OUTPUT_DISABLE 0
`define CFG_XC_RATIO_LO 1
`define CFG_XC_RATIO_HI 2
`define CFG_XC_RATIO_RST 2'h2

// ----------------------------------------------------------------------------
// Divide codes of the tick divider: /1, /2, /4
// ----------------------------------------------------------------------------
`define CFG_DIV1 2'h0
`define CFG_DIV2 2'h1
`define CFG_DIV4 2'h2

// ----------------------------------------------------------------------------
// Counter widths and default counts
// ----------------------------------------------------------------------------
`define CFG_OSC_CNT_W 7
`define CFG_VCO_CNT_W 13
`define CFG_LOCK_CYCLES 1024
`define CFG_PWRUP_CYCLES 1024
`define CFG_WAIT_W 16

`endif

// File: clk_pkg.sv
// Purpose: Types shared by the clock control block
// Assumes: clk_cfg.svh holds all numbers
// Notes:   One-hot PLL state codes
package clk_pkg;

  // ----------------------------------------------------------------------------
  // PLL sequencing state
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_BYPASS = 3'b001,
    ST_LOCKING = 3'b010,
    ST_LOCKED = 3'b100
  } pll_state_t;

  // ----------------------------------------------------------------------------
  // CPU clock source
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_OSC = 2'h0,
    SRC_PLL = 2'h1,
    SRC_LIMP = 2'h2
  } cpu_src_t;

endpackage : clk_pkg

// File: tick_div.sv
// Purpose: Enable-pulse divider, divides an input tick stream by 1, 2 or 4
// Assumes: i_en is a one-cycle tick in the I_CLK domain
// Notes:   Output tick is registered
`include "clk_cfg.svh"

module tick_div (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_en,
  input wire logic [1:0] i_sel,
  output logic o_tick
);

  logic [1:0] cnt;
  logic [1:0] last;

  always_comb begin
    case (i_sel)
      `CFG_DIV1: last = 2'h0;
      `CFG_DIV2: last = 2'h1;
      default: last = 2'h3;
    endcase
  end

  // ----------------------------------------------------------------------------
  // Count and tick
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt <= 2'h0;
      o_tick <= 1'b0;
    end else if (!i_en) begin
      o_tick <= 1'b0;
    end else if (cnt >= last) begin
      cnt <= 2'h0;
      o_tick <= 1'b1;
    end else begin
      cnt <= cnt + 2'h1;
      o_tick <= 1'b0;
    end
  end

endmodule : tick_div

// File: pll_clock_select_and_fail_detect.sv
// Purpose: CPU clock select, PLL lock sequencing, oscillator fail detection, clock-out divider
// Assumes: All inputs synchronous to I_CLK; oscillator and VCO arrive as one-cycle ticks
// Notes:   Registers on Avalon-MM with one wait state per access
`include "clk_cfg.svh"

module pll_clock_select_and_fail_detect #(
  parameter int LOCK_CYCLES = `CFG_LOCK_CYCLES,
  parameter int PWRUP_CYCLES = `CFG_PWRUP_CYCLES
) (
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic I_EXT_RST_N,
  input wire logic I_WDOG_RST,
  input wire logic I_PROT_WR_EN,
  input wire logic I_STANDBY,
  input wire logic I_HALT,
  input wire logic I_OSC_TICK,
  input wire logic I_VCO_TICK,
  input wire logic [`CFG_ADDR_W-1:0] I_ADDRESS,
  input wire logic I_READ,
  input wire logic I_WRITE,
  input wire logic [31:0] I_WRITEDATA,
  output logic [31:0] O_READDATA,
  output logic O_WAITREQUEST,
  output clk_pkg::cpu_src_t O_CPU_SRC,
  output logic [1:0] O_CPU_DIV,
  output logic [3:0] O_PLL_RATIO,
  output logic O_CPU_CLK_RUN,
  output logic O_SYSCLK_TICK,
  output logic O_EXT_CLK_TICK,
  output logic O_MISSING_CLOCK_RESET
);
  import clk_pkg::*;

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  pll_state_t state;
  logic [3:0] ratio;
  logic [1:0] cpu_clock_divide_select;
  logic mclk_off;
  logic mclk_flag;
  logic locked;
  logic clk_off;
  logic [1:0] xratio;
  logic limp;
  logic halt_d;
  logic pwr_busy;
  logic [`CFG_WAIT_W-1:0] pwr_cnt;
  logic [`CFG_WAIT_W-1:0] lock_cnt;
  logic [`CFG_OSC_CNT_W-1:0] osc_cnt;
  logic [`CFG_VCO_CNT_W-1:0] vco_cnt;
  logic pll_rst;
  logic wr;
  logic rd;
  logic wr_mult;
  logic wr_stat;
  logic wr_xcfg;
  logic mclk_clr;
  logic mon_en;
  logic osc_ovf;
  logic vco_ovf;
  logic miss;
  logic sys_run;
  logic [1:0] next_div;
  logic [1:0] ext_sel;
  logic sys_tick;
  logic ext_tick;
  logic [31:0] next_rdata;

  // Only the reset pin and the watchdog touch the PLL registers
  assign pll_rst = !I_EXT_RST_N || I_WDOG_RST;

  // ----------------------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------------------
  // Every access takes one wait state, so read data come from a flop
  assign wr = I_WRITE && !O_WAITREQUEST;
  assign rd = I_READ && O_WAITREQUEST;
  assign wr_mult = wr && (I_ADDRESS == `CFG_OFS_MULT);
  assign wr_stat = wr && (I_ADDRESS == `CFG_OFS_STATUS);
  assign wr_xcfg = wr && (I_ADDRESS == `CFG_OFS_XCFG);
  assign mclk_clr = wr_stat && I_WRITEDATA[`CFG_ST_MCLK_CLR];

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_WAITREQUEST <= 1'b1;
    end else if ((I_READ || I_WRITE) && O_WAITREQUEST) begin
      O_WAITREQUEST <= 1'b0;
    end else begin
      O_WAITREQUEST <= 1'b1;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (I_ADDRESS)
      `CFG_OFS_MULT: next_rdata[3:0] = ratio;
      `CFG_OFS_STATUS: begin
        next_rdata[`CFG_ST_LOCKED] = locked;
        next_rdata[`CFG_ST_MCLK_FLAG] = mclk_flag;
        next_rdata[`CFG_ST_MCLK_OFF] = mclk_off;
        next_rdata[`CFG_ST_CPU_CLOCK_DIVIDE_SELECT_HI:`CFG_ST_CPU_CLOCK_DIVIDE_SELECT_LO] = cpu_clock_divide_select;
      end
      `CFG_OFS_XCFG: begin
        next_rdata[`CFG_XC_EXT_CLOCK_OUTPUT_DISABLE] = clk_off;
        next_rdata[`CFG_XC_RATIO_HI:`CFG_XC_RATIO_LO] = xratio;
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_READDATA <= 32'h0000_0000;
    end else if (rd) begin
      O_READDATA <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------------
  // Status register control bits
  // ----------------------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      cpu_clock_divide_select <= 2'h0;
      mclk_off <= 1'b0;
    end else if (pll_rst) begin
      cpu_clock_divide_select <= 2'h0;
      mclk_off <= 1'b0;
    end else if (wr_stat) begin
      cpu_clock_divide_select <= I_WRITEDATA[`CFG_ST_CPU_CLOCK_DIVIDE_SELECT_HI:`CFG_ST_CPU_CLOCK_DIVIDE_SELECT_LO];
      mclk_off <= I_WRITEDATA[`CFG_ST_MCLK_OFF];
    end
  end

  // Write data to the flag bit itself is never looked at
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      mclk_flag <= 1'b0;
    end else if (!I_EXT_RST_N) begin
      mclk_flag <= 1'b0;
    end else if (miss) begin
      mclk_flag <= 1'b1;
    end else if (mclk_clr) begin
      mclk_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Multiplier register and lock sequencing
  // ----------------------------------------------------------------------------
  // Reserved ratio codes are dropped so the PLL never sees them
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ratio <= `CFG_RATIO_BYPASS;
      state <= ST_BYPASS;
      locked <= 1'b0;
      lock_cnt <= '0;
    end else if (pll_rst) begin
      ratio <= `CFG_RATIO_BYPASS;
      state <= ST_BYPASS;
      locked <= 1'b0;
      lock_cnt <= '0;
    end else if (wr_mult && I_PROT_WR_EN && I_WRITEDATA[3:0] <= `CFG_RATIO_MAX) begin
      ratio <= I_WRITEDATA[3:0];
      locked <= 1'b0;
      lock_cnt <= '0;
      state <= (I_WRITEDATA[3:0] == `CFG_RATIO_BYPASS) ? ST_BYPASS : ST_LOCKING;
    end else begin
      case (state)
        ST_LOCKING: begin
          if (!pwr_busy && !I_HALT) begin
            if (lock_cnt == LOCK_CYCLES[`CFG_WAIT_W-1:0] - 1'b1) begin
              state <= ST_LOCKED;
              locked <= 1'b1;
            end else begin
              lock_cnt <= lock_cnt + 1'b1;
            end
          end
        end
        ST_LOCKED: state <= ST_LOCKED;
        ST_BYPASS: state <= ST_BYPASS;
        default: state <= ST_BYPASS;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Halt exit power-up
  // ----------------------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      halt_d <= 1'b0;
      pwr_busy <= 1'b0;
      pwr_cnt <= '0;
    end else begin
      halt_d <= I_HALT;
      if (halt_d && !I_HALT) begin
        pwr_busy <= 1'b1;
        pwr_cnt <= '0;
      end else if (pwr_busy) begin
        if (pwr_cnt == PWRUP_CYCLES[`CFG_WAIT_W-1:0] - 1'b1) begin
          pwr_busy <= 1'b0;
        end else begin
          pwr_cnt <= pwr_cnt + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Oscillator fail detection
  // ----------------------------------------------------------------------------
  // Counters sleep in halt and during power-up, keep watching in standby
  assign mon_en = !mclk_off && !I_HALT && !pwr_busy && !mclk_flag;
  assign osc_ovf = mon_en && I_OSC_TICK && (&osc_cnt);
  assign vco_ovf = mon_en && I_VCO_TICK && (&vco_cnt) && !osc_ovf;
  assign miss = vco_ovf;

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      osc_cnt <= '0;
      vco_cnt <= '0;
    end else if (!mon_en || mclk_clr) begin
      osc_cnt <= '0;
      vco_cnt <= '0;
    end else begin
      if (I_OSC_TICK) begin
        osc_cnt <= osc_cnt + 1'b1;
      end
      if (osc_ovf) begin
        vco_cnt <= '0;
      end else if (I_VCO_TICK) begin
        vco_cnt <= vco_cnt + 1'b1;
      end
    end
  end

  // Limp selection survives the missing-clock reset; cleared with the flag
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      limp <= 1'b0;
      O_MISSING_CLOCK_RESET <= 1'b0;
    end else begin
      O_MISSING_CLOCK_RESET <= miss;
      if (!I_EXT_RST_N) begin
        limp <= 1'b0;
      end else if (miss) begin
        limp <= 1'b1;
      end else if (mclk_clr) begin
        limp <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // CPU clock source and divide
  // ----------------------------------------------------------------------------
  // A bypassed limp clock is never passed on undivided
  always_comb begin
    case (cpu_clock_divide_select)
      `CFG_CPU_CLOCK_DIVIDE_SELECT_BY2: next_div = `CFG_DIV2;
      `CFG_CPU_CLOCK_DIVIDE_SELECT_BY1: next_div = (state == ST_BYPASS && !limp) ? `CFG_DIV1 : `CFG_DIV2;
      default: next_div = `CFG_DIV4;
    endcase
    if (!I_EXT_RST_N) begin
      next_div = `CFG_DIV4;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_CPU_SRC <= SRC_OSC;
      O_CPU_DIV <= `CFG_DIV4;
      O_PLL_RATIO <= `CFG_RATIO_BYPASS;
      O_CPU_CLK_RUN <= 1'b0;
    end else begin
      if (limp) begin
        O_CPU_SRC <= SRC_LIMP;
      end else if (state == ST_LOCKED) begin
        O_CPU_SRC <= SRC_PLL;
      end else begin
        O_CPU_SRC <= SRC_OSC;
      end
      O_CPU_DIV <= next_div;
      O_PLL_RATIO <= ratio;
      O_CPU_CLK_RUN <= !I_STANDBY && !I_HALT;
    end
  end

  // ----------------------------------------------------------------------------
  // System clock and external clock output
  // ----------------------------------------------------------------------------
  // External reset does not stop the dividers, so the clock output stays observable
  assign sys_run = !I_HALT && (!I_STANDBY || !I_EXT_RST_N);
  assign ext_sel = !I_EXT_RST_N ? `CFG_DIV4 : xratio;

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      clk_off <= 1'b0;
      xratio <= `CFG_XC_RATIO_RST;
    end else if (!I_EXT_RST_N) begin
      clk_off <= 1'b0;
      xratio <= `CFG_XC_RATIO_RST;
    end else if (wr_xcfg) begin
      clk_off <= I_WRITEDATA[`CFG_XC_EXT_CLOCK_OUTPUT_DISABLE];
      xratio <= I_WRITEDATA[`CFG_XC_RATIO_HI:`CFG_XC_RATIO_LO];
    end
  end

  tick_div u_sys_div (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_en(sys_run),
    .i_sel(next_div),
    .o_tick(sys_tick)
  );

  tick_div u_ext_div (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_en(sys_tick),
    .i_sel(ext_sel),
    .o_tick(ext_tick)
  );

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_SYSCLK_TICK <= 1'b0;
      O_EXT_CLK_TICK <= 1'b0;
    end else begin
      O_SYSCLK_TICK <= sys_tick;
      O_EXT_CLK_TICK <= ext_tick && (!clk_off || !I_EXT_RST_N);
    end
  end

endmodule : pll_clock_select_and_fail_detect

// File: pll_clock_select_and_fail_detect_asserts.sv
// Purpose: Port-level checks of the clock control block
// Assumes: One clock domain, I_RSTN async active low
// Notes:   Bound to the top module at the foot of this file
`include "clk_cfg.svh"

module pll_clk_checker #(
  parameter int LOCK_CYCLES = 4
) (
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic I_STANDBY,
  input wire logic I_HALT,
  input wire clk_pkg::cpu_src_t O_CPU_SRC,
  input wire logic [1:0] O_CPU_DIV,
  input wire logic [3:0] O_PLL_RATIO,
  input wire logic O_CPU_CLK_RUN,
  input wire logic O_MISSING_CLOCK_RESET
);
  import clk_pkg::*;
  // Slack covers the write-to-register latency before counting starts
  localparam int LOCK_MAX = LOCK_CYCLES + 8;
  default clocking dcb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RSTN);
  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  run_gate_a: assert property (I_STANDBY || I_HALT |=> !O_CPU_CLK_RUN)
    else $error("cpu clock runs in low power mode");
  mclk_pulse_a: assert property (O_MISSING_CLOCK_RESET |=> !O_MISSING_CLOCK_RESET)
    else $error("missing clock reset longer than one cycle");
  limp_route_a: assert property ($rose(O_MISSING_CLOCK_RESET) |-> ##[0:1] O_CPU_SRC == SRC_LIMP)
    else $error("no limp source after missing clock");
  halt_quiet_a: assert property (I_HALT [*3] |-> !O_MISSING_CLOCK_RESET)
    else $error("missing clock reset during halt");
  ratio_range_a: assert property (O_PLL_RATIO <= `CFG_RATIO_MAX)
    else $error("reserved ratio taken");
  div1_bypass_a: assert property (O_CPU_DIV == `CFG_DIV1 |-> O_CPU_SRC != SRC_PLL)
    else $error("divide by one with pll");
  bypass_src_a: assert property (O_PLL_RATIO == 4'h0 && $stable(O_PLL_RATIO) |-> O_CPU_SRC != SRC_PLL)
    else $error("pll source in bypass");
  lock_hold_a: assert property ($changed(O_PLL_RATIO) && O_PLL_RATIO != 4'h0 |-> O_CPU_SRC != SRC_PLL)
    else $error("pll source before lock");
  lock_done_a: assert property ($changed(O_PLL_RATIO) && O_PLL_RATIO != 4'h0 |-> ##[1:LOCK_MAX] O_CPU_SRC == SRC_PLL)
    else $error("no switch to pll after lock");
  cov_mclk_c: cover property (O_MISSING_CLOCK_RESET);
  cov_pll_c: cover property (O_CPU_SRC == SRC_PLL);
  cov_halt_c: cover property (I_HALT ##1 !I_HALT);
endmodule : pll_clk_checker

bind pll_clock_select_and_fail_detect pll_clk_checker #(.LOCK_CYCLES(LOCK_CYCLES)) i_chk (
  .I_CLK, .I_RSTN, .I_STANDBY, .I_HALT, .O_CPU_SRC, .O_CPU_DIV, .O_PLL_RATIO,
  .O_CPU_CLK_RUN, .O_MISSING_CLOCK_RESET
);

// File: tb.sv
// Purpose: Self-checking bench for the clock control block
// Assumes: Lock count shortened to 40, power-up count to 4
// Notes:   Oscillator ticks and ratios drawn from a fixed seed
`include "clk_cfg.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import clk_pkg::*;
  logic clk = 0, rstn = 0, xrst_n = 1, wdog = 0, prot = 1, stby = 0, halt = 0;
  logic osc = 0, vco = 0, rd = 0, wr = 0, osc_on = 1, run, stk, etk, mrst, wreq;
  logic [3:0] addr = 0, ratio, r;
  logic [31:0] wd = 0, rdat, q, rnd;
  logic [1:0] div;
  cpu_src_t src;
  integer seed = 32'h51DA;
  int fails = 0, num_checks = 0, cycles = 0, per;

  pll_clock_select_and_fail_detect #(.LOCK_CYCLES(40), .PWRUP_CYCLES(4)) i_dut (
    .I_CLK(clk), .I_RSTN(rstn), .I_EXT_RST_N(xrst_n), .I_WDOG_RST(wdog),
    .I_PROT_WR_EN(prot), .I_STANDBY(stby), .I_HALT(halt), .I_OSC_TICK(osc),
    .I_VCO_TICK(vco), .I_ADDRESS(addr), .I_READ(rd), .I_WRITE(wr), .I_WRITEDATA(wd),
    .O_READDATA(rdat), .O_WAITREQUEST(wreq), .O_CPU_SRC(src), .O_CPU_DIV(div),
    .O_PLL_RATIO(ratio), .O_CPU_CLK_RUN(run), .O_SYSCLK_TICK(stk),
    .O_EXT_CLK_TICK(etk), .O_MISSING_CLOCK_RESET(mrst)
  );

  // --------------------------------------------------------------------------
  // Clock, oscillator stimulus, timeout
  // --------------------------------------------------------------------------
  always #25 clk = ~clk;
  // A lost oscillator leaves the VCO ticking every cycle, so overflow comes fast
  always @(posedge clk) begin
    rnd = $random(seed);
    osc <= osc_on & rnd[0];
    vco <= rnd[1] | !osc_on;
    cycles++;
    if (cycles == 60000) begin
      fails++;
      summarize();
    end
  end

  task automatic summarize();
    if (fails == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  // --------------------------------------------------------------------------
  // Bus and measurement helpers
  // --------------------------------------------------------------------------
  task automatic bus(input bit w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    rd <= !w;
    wr <= w;
    addr <= a;
    wd <= d;
    @(posedge clk);
    while (wreq !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) fails++;
    q = rdat;
    rd <= 0;
    wr <= 0;
    repeat (3) @(posedge clk);
  endtask : bus

  task automatic ext_per();
    int n;
    n = 0;
    per = 0;
    while (etk !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    do begin
      @(posedge clk);
      n++;
      if (stk === 1'b1) per++;
    end while (etk !== 1'b1 && n < 400);
  endtask : ext_per

  task automatic lock();
    int n;
    n = 0;
    q = 0;
    while (q[0] !== 1'b1 && n < 20) begin
      bus(0, `CFG_OFS_STATUS, 0);
      n++;
    end
    `CHK(q[0], 1'b1)
  endtask : lock

  function automatic logic [1:0] exp_div(input logic [1:0] sel, input bit byp);
    case (sel)
      2'h2: return `CFG_DIV2;
      2'h3: return byp ? `CFG_DIV1 : `CFG_DIV2;
      default: return `CFG_DIV4;
    endcase
  endfunction : exp_div

  task automatic sweep(input bit byp);
    for (int s = 0; s < 4; s++) begin
      bus(1, `CFG_OFS_STATUS, 32'(s << 7));
      `CHK(div, exp_div(2'(s), byp))
    end
    bus(1, `CFG_OFS_STATUS, 0);
  endtask : sweep

  task automatic lose_osc();
    int n;
    n = 0;
    osc_on <= 0;
    while (mrst !== 1'b1 && n < 9500) begin
      @(posedge clk);
      n++;
    end
    `CHK(mrst, 1'b1)
    osc_on <= 1;
    repeat (2) @(posedge clk);
    `CHK(src, SRC_LIMP)
    `CHK(div, `CFG_DIV4)
    bus(0, `CFG_OFS_STATUS, 0);
    `CHK(q[3], 1'b1)
    bus(1, `CFG_OFS_STATUS, 0);
    bus(0, `CFG_OFS_STATUS, 0);
    `CHK(q[3], 1'b1)
    bus(1, `CFG_OFS_STATUS, 32'h10);
    bus(0, `CFG_OFS_STATUS, 0);
    `CHK(q[3], 1'b0)
  endtask : lose_osc

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1;
    bus(0, `CFG_OFS_MULT, 0);
    `CHK(q, 32'h0)
    bus(0, `CFG_OFS_STATUS, 0);
    `CHK(q, 32'h0)
    bus(0, `CFG_OFS_XCFG, 0);
    `CHK(q, 32'h4)
    bus(0, 4'hC, 0);
    `CHK(q, 32'h0)
    `CHK(src, SRC_OSC)
    `CHK(div, `CFG_DIV4)
    `CHK(run, 1'b1)
    prot <= 0;
    bus(1, `CFG_OFS_MULT, 5);
    prot <= 1;
    bus(1, `CFG_OFS_MULT, 32'hB);
    bus(0, `CFG_OFS_MULT, 0);
    `CHK(q, 32'h0)
    for (int i = 0; i < 3; i++) begin
      r = (i == 0) ? 4'hA : 4'(1 + rnd[7:0] % 10);
      bus(1, `CFG_OFS_STATUS, 32'h40);
      bus(1, `CFG_OFS_MULT, {28'h0, r});
      `CHK(src, SRC_OSC)
      bus(0, `CFG_OFS_STATUS, 0);
      `CHK(q[0], 1'b0)
      lock();
      `CHK(src, SRC_PLL)
      `CHK(ratio, r)
      sweep(0);
    end
    lose_osc();
    `CHK(ratio, r)
    bus(1, `CFG_OFS_MULT, 0);
    `CHK(src, SRC_OSC)
    sweep(1);
    stby <= 1;
    repeat (2) @(posedge clk);
    `CHK(run, 1'b0)
    per = 0;
    repeat (20) begin
      @(posedge clk);
      if (stk === 1'b1) per++;
    end
    `CHK(per, 0)
    lose_osc();
    stby <= 0;
    halt <= 1;
    osc_on <= 0;
    per = 0;
    repeat (9000) begin
      @(posedge clk);
      if (mrst === 1'b1) per++;
    end
    `CHK(per, 0)
    `CHK(run, 1'b0)
    halt <= 0;
    lose_osc();
    bus(1, `CFG_OFS_STATUS, 32'h40);
    bus(1, `CFG_OFS_MULT, 7);
    lock();
    wdog <= 1;
    @(posedge clk);
    wdog <= 0;
    repeat (3) @(posedge clk);
    `CHK(ratio, 4'h0)
    `CHK(src, SRC_OSC)
    for (int x = 0; x < 4; x++) begin
      bus(1, `CFG_OFS_XCFG, 32'(x << 1));
      ext_per();
      ext_per();
      `CHK(per, (x == 3) ? 4 : 1 << x)
    end
    bus(1, `CFG_OFS_MULT, 2);
    lock();
    bus(1, `CFG_OFS_XCFG, 1);
    per = 0;
    repeat (64) begin
      @(posedge clk);
      if (etk === 1'b1) per++;
    end
    `CHK(per, 0)
    xrst_n <= 0;
    ext_per();
    ext_per();
    `CHK(per, 4)
    `CHK(ratio, 4'h0)
    xrst_n <= 1;
    repeat (2) @(posedge clk);
    bus(0, `CFG_OFS_XCFG, 0);
    `CHK(q, 32'h4)
    summarize();
  end
endmodule : tb
